// *** hw/cmc_clock_mode_cfg.sv ***
// Overview of operation
// - six-bit mode from three pins and three reset-word bits at power-on release
// - clock configuration changes only when power-on reset deasserts
// - serial controller clock divides by fixed four
// - baud divider field bits 30-31: 4,16,64,256; power-on loads 01
// - baud divider rewritable after power-on release without disturbing other clocks
// - bit 27 disables external clock output; power-on clears it
// - control register reachable by memory-mapped access
// - mode register at 0x10C88 read-only, drives PLL, DLL, clock controls
// - all mode fields loaded during power-on reset only
// - core PLL prediv codes 0-3 mean factors 1-4
// - core PLL multiplier codes 5,6,7 mean 10,12,14
// - bus divider codes 1-5 mean 2-6
// - comm processor divider codes 0-2 mean 1-3
// - system PLL prediv codes 0-5 mean 1-6
// - system PLL multiplier codes 5-15 mean 10-30 by twos
// - bit 25 disables the delay loop when set
// - core divider codes 0-5 mean 1-6
`timescale 1ns/10ps
module cmc_clock_mode_cfg
    import cmc_pkg::*;
#(
    parameter logic DLL_OFF   = 1'b0,
    parameter int   BRG_CNT_W = CMC_BRG_CNT_W
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic         power_on_reset_n_in,
    input  wire logic [2:0]   mode_select_pins_in,
    input  wire logic [2:0]   reset_word_mode_bits_in,
    input  wire cmc_reg_req_t reg_req_in,
    output logic [31:0]       reg_rdata_out,
    output logic              reg_rvalid_out,
    output cmc_mode_t         clock_mode_out,
    output logic              mode_valid_out,
    output cmc_ctrl_t         clock_ctrl_out,
    output logic              scc_clk_en_out,
    output logic              baud_gen_clk_en_out,
    output logic              external_clock_output_out
);

    // ==========================================================
    // elaboration checks
    if (BRG_CNT_W < CMC_BRG_CNT_W) begin : g_chk
        $error("cmc_clock_mode_cfg: BRG_CNT_W too small for divide by 256");
    end

    // ==========================================================
    // mode decode
    function automatic cmc_mode_t mode_decode(input logic [5:0] m);
        cmc_mode_t d;
        d.core_pll_prediv       = {2'h0, m[1:0]};
        d.core_pll_multiplier   = CMC_CORE_MF_MIN + {3'h0, m[2]};
        d.bus_divider           = CMC_BUS_DF_MIN + {2'h0, m[4:3]};
        d.comm_proc_divider     = {3'h0, m[5]};
        d.system_pll_prediv     = {3'h0, m[3]};
        d.system_pll_multiplier = CMC_SYSTEM_PLL_MF_MIN + {1'h0, m[2:0]};
        d.delay_loop_disable    = DLL_OFF;
        d.core_divider          = {2'h0, m[5:4]};
        return d;
    endfunction

    // ==========================================================
    // input synchronisers
    logic       por_rel;
    logic [2:0] pins_s;

    cmc_pin_sync #(
        .WIDTH   (1),
        .RST_VAL (16'h0000)
    ) u_por_sync (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .pin_in    (power_on_reset_n_in),
        .level_out (por_rel)
    );

    cmc_pin_sync #(
        .WIDTH   (3),
        .RST_VAL (16'h0000)
    ) u_pin_sync (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .pin_in    (mode_select_pins_in),
        .level_out (pins_s)
    );

    // ==========================================================
    // power-on sequencing
    cmc_state_t state_q;
    logic       release_ev;
    logic [5:0] mode_raw;

    assign mode_raw   = {reset_word_mode_bits_in, pins_s};
    assign release_ev = (state_q == CMC_ST_HOLD) && por_rel;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_q <= CMC_ST_HOLD;
        end else begin
            case (state_q)
                CMC_ST_HOLD: begin
                    if (por_rel) begin
                        state_q <= CMC_ST_RUN;
                    end
                end
                CMC_ST_RUN: begin
                    if (!por_rel) begin
                        state_q <= CMC_ST_HOLD;
                    end
                end
                default: begin
                    state_q <= CMC_ST_HOLD;
                end
            endcase
        end
    end

    // ==========================================================
    // clock_mode_status register
    cmc_mode_t mode_q;
    logic      mode_valid_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mode_q <= '0;
        end else if (release_ev) begin
            mode_q <= mode_decode(mode_raw);
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mode_valid_q <= 1'b0;
        end else if (release_ev) begin
            mode_valid_q <= 1'b1;
        end
    end

    assign clock_mode_out = mode_q;
    assign mode_valid_out = mode_valid_q;

    // ==========================================================
    // clock_control register
    cmc_ctrl_t ctrl_q;
    logic      wr_ctrl;
    logic      wr_mode;
    logic      rd_ctrl;
    logic      rd_mode;

    assign wr_ctrl = reg_req_in.wr && (reg_req_in.addr == CMC_CLOCK_CONTROL_OFS);
    assign wr_mode = reg_req_in.wr && (reg_req_in.addr == CMC_MODE_STATUS_OFS);
    assign rd_ctrl = reg_req_in.rd && (reg_req_in.addr == CMC_CLOCK_CONTROL_OFS);
    assign rd_mode = reg_req_in.rd && (reg_req_in.addr == CMC_MODE_STATUS_OFS);

    // reserved bits are not stored
    always_ff @(posedge clk_in) begin
        if (rst_in || state_q == CMC_ST_HOLD) begin
            ctrl_q.clock_output_disable <= CMC_CLOCK_OUTPUT_DISABLE_RST;
            ctrl_q.baud_gen_divider     <= CMC_BAUD_GEN_DIVIDER_RST;
        end else if (wr_ctrl) begin
            ctrl_q.clock_output_disable <= reg_req_in.wdata[CMC_CLOCK_OUTPUT_DISABLE_BIT];
            ctrl_q.baud_gen_divider     <= reg_req_in.wdata[CMC_BAUD_GEN_DIVIDER_LSB +: 2];
        end
    end

    assign clock_ctrl_out = ctrl_q;

    // ==========================================================
    // read port
    logic [31:0] rdata_q;
    logic        rvalid_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_q <= '0;
        end else if (rd_mode) begin
            rdata_q <= cmc_mode_word(mode_q);
        end else if (rd_ctrl) begin
            rdata_q                                <= '0;
            rdata_q[CMC_CLOCK_OUTPUT_DISABLE_BIT]               <= ctrl_q.clock_output_disable;
            rdata_q[CMC_BAUD_GEN_DIVIDER_LSB +: 2]            <= ctrl_q.baud_gen_divider;
        end else if (reg_req_in.rd) begin
            rdata_q <= '0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_req_in.rd;
        end
    end

    assign reg_rdata_out  = rdata_q;
    assign reg_rvalid_out = rvalid_q;

    // ==========================================================
    // serial controller divider, fixed by four
    logic [1:0] scc_cnt_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            scc_cnt_q <= '0;
        end else begin
            scc_cnt_q <= scc_cnt_q + 2'h1;
        end
    end

    assign scc_clk_en_out = (scc_cnt_q == CMC_SCC_LAST);

    // ==========================================================
    // baud generator divider
    logic [BRG_CNT_W-1:0] brg_cnt_q;
    logic [BRG_CNT_W-1:0] brg_last;

    assign brg_last = BRG_CNT_W'(cmc_brg_last(ctrl_q.baud_gen_divider));

    // restart cleanly on a new divider, other clocks untouched
    always_ff @(posedge clk_in) begin
        if (rst_in || wr_ctrl) begin
            brg_cnt_q <= '0;
        end else if (brg_cnt_q >= brg_last) begin
            brg_cnt_q <= '0;
        end else begin
            brg_cnt_q <= brg_cnt_q + BRG_CNT_W'(1);
        end
    end

    assign baud_gen_clk_en_out = (brg_cnt_q == brg_last);

    // ==========================================================
    // external clock output at bus rate
    logic [3:0] bus_cnt_q;
    logic       external_clock_output_q;
    logic       external_clock_output_run;

    assign external_clock_output_run = (state_q == CMC_ST_RUN) && !ctrl_q.clock_output_disable;

    always_ff @(posedge clk_in) begin
        if (rst_in || !external_clock_output_run) begin
            bus_cnt_q <= '0;
        end else if (bus_cnt_q >= mode_q.bus_divider) begin
            bus_cnt_q <= '0;
        end else begin
            bus_cnt_q <= bus_cnt_q + 4'h1;
        end
    end

    // held low while disabled
    always_ff @(posedge clk_in) begin
        if (rst_in || !external_clock_output_run) begin
            external_clock_output_q <= 1'b0;
        end else begin
            external_clock_output_q <= (bus_cnt_q < ((mode_q.bus_divider + 4'h1) >> 1));
        end
    end

    assign external_clock_output_out = external_clock_output_q;

    // ==========================================================
    // assertions
    sequence s_release;
        (state_q == CMC_ST_HOLD) && por_rel;
    endsequence

    sequence s_scc_gap;
        !scc_clk_en_out [*3] ##1 scc_clk_en_out;
    endsequence

    a_mode_latch_pins : assert property (@(posedge clk_in) disable iff (rst_in)
        s_release |=> (clock_mode_out == mode_decode($past(mode_raw))) && mode_valid_out)
        else $error("mode not latched from pins at release");

    a_mode_hold_run : assert property (@(posedge clk_in) disable iff (rst_in)
        !release_ev |=> $stable(clock_mode_out))
        else $error("mode changed outside power-on release");

    a_mode_write_ignored : assert property (@(posedge clk_in) disable iff (rst_in)
        wr_mode && !release_ev |=> $stable(clock_mode_out))
        else $error("mode register took a write");

    a_mode_read_back : assert property (@(posedge clk_in) disable iff (rst_in)
        rd_mode |=> reg_rvalid_out && (reg_rdata_out == cmc_mode_word($past(clock_mode_out))))
        else $error("mode read data wrong");

    a_scc_by_four : assert property (@(posedge clk_in) disable iff (rst_in)
        scc_clk_en_out |=> s_scc_gap)
        else $error("serial clock enable not every fourth cycle");

    a_brg_por_default : assert property (@(posedge clk_in) disable iff (rst_in)
        state_q == CMC_ST_HOLD |=> clock_ctrl_out.baud_gen_divider == CMC_BAUD_GEN_DIVIDER_RST)
        else $error("baud divider not at default during power-on");

    a_brg_write_takes : assert property (@(posedge clk_in) disable iff (rst_in)
        wr_ctrl && state_q == CMC_ST_RUN && por_rel
        |=> clock_ctrl_out.baud_gen_divider == $past(reg_req_in.wdata[CMC_BAUD_GEN_DIVIDER_LSB +: 2])
            && brg_cnt_q == '0)
        else $error("baud divider write not taken cleanly");

    a_brg_div4_rate : assert property (@(posedge clk_in) disable iff (rst_in)
        baud_gen_clk_en_out && clock_ctrl_out.baud_gen_divider == 2'h0 && !wr_ctrl
        ##1 !wr_ctrl [*3] |=> baud_gen_clk_en_out)
        else $error("divide by four baud rate wrong");

    a_external_clock_output_disabled : assert property (@(posedge clk_in) disable iff (rst_in)
        clock_ctrl_out.clock_output_disable |=> !external_clock_output_out)
        else $error("clock output active while disabled");

    a_fields_valid : assert property (@(posedge clk_in) disable iff (rst_in)
        mode_valid_out |-> clock_mode_out.core_pll_prediv <= CMC_CORE_PDF_MAX
            && clock_mode_out.core_pll_multiplier inside {[CMC_CORE_MF_MIN:CMC_CORE_MF_MAX]}
            && clock_mode_out.bus_divider inside {[CMC_BUS_DF_MIN:CMC_BUS_DF_MAX]}
            && clock_mode_out.comm_proc_divider <= CMC_CPM_DF_MAX
            && clock_mode_out.system_pll_prediv <= CMC_SYSTEM_PLL_PDF_MAX
            && clock_mode_out.system_pll_multiplier >= CMC_SYSTEM_PLL_MF_MIN
            && clock_mode_out.core_divider <= CMC_CORE_DF_MAX)
        else $error("mode field holds an unused code");

    a_dll_disable : assert property (@(posedge clk_in) disable iff (rst_in)
        mode_valid_out |-> clock_mode_out.delay_loop_disable == DLL_OFF)
        else $error("delay loop disable bit wrong");

    a_clock_output_disable_por_clear : assert property (@(posedge clk_in) disable iff (rst_in)
        state_q == CMC_ST_HOLD |=> !clock_ctrl_out.clock_output_disable)
        else $error("clock output disable not cleared at power-on");

    a_ctrl_hold_run : assert property (@(posedge clk_in) disable iff (rst_in)
        state_q == CMC_ST_RUN && !wr_ctrl |=> $stable(clock_ctrl_out))
        else $error("control register changed without a write");

    a_read_answer : assert property (@(posedge clk_in) disable iff (rst_in)
        1'b1 |=> reg_rvalid_out == $past(reg_req_in.rd))
        else $error("read answer pulse wrong");

    a_ctrl_read_back : assert property (@(posedge clk_in) disable iff (rst_in)
        rd_ctrl |=> reg_rdata_out[CMC_BAUD_GEN_DIVIDER_LSB +: 2] == $past(clock_ctrl_out.baud_gen_divider)
            && reg_rdata_out[CMC_CLOCK_OUTPUT_DISABLE_BIT] == $past(clock_ctrl_out.clock_output_disable))
        else $error("control read data wrong");

endmodule

// *** hw/cmc_pkg.sv ***
package cmc_pkg;

    // ==========================================================
    // register bus
    localparam int          CMC_DATA_W            = 32;
    localparam int          CMC_ADDR_W            = 20;
    localparam logic [19:0] CMC_CLOCK_CONTROL_OFS = 20'h10C80;
    localparam logic [19:0] CMC_MODE_STATUS_OFS   = 20'h10C88;

    // ==========================================================
    // clock_mode_status field layout
    localparam int CMC_FIELD_W       = 4;
    localparam int CMC_CORE_PDF_LSB  = 0;
    localparam int CMC_CORE_MF_LSB   = 4;
    localparam int CMC_BUS_DF_LSB    = 8;
    localparam int CMC_CPM_DF_LSB    = 12;
    localparam int CMC_SYSTEM_PLL_PDF_LSB  = 16;
    localparam int CMC_SYSTEM_PLL_MF_LSB   = 20;
    localparam int CMC_DLL_DIS_BIT   = 25;
    localparam int CMC_CORE_DF_LSB   = 28;

    // valid code ranges
    localparam logic [3:0] CMC_CORE_PDF_MAX = 4'h3;
    localparam logic [3:0] CMC_CORE_MF_MIN  = 4'h5;
    localparam logic [3:0] CMC_CORE_MF_MAX  = 4'h7;
    localparam logic [3:0] CMC_BUS_DF_MIN   = 4'h1;
    localparam logic [3:0] CMC_BUS_DF_MAX   = 4'h5;
    localparam logic [3:0] CMC_CPM_DF_MAX   = 4'h2;
    localparam logic [3:0] CMC_SYSTEM_PLL_PDF_MAX = 4'h5;
    localparam logic [3:0] CMC_SYSTEM_PLL_MF_MIN  = 4'h5;
    localparam logic [3:0] CMC_CORE_DF_MAX  = 4'h5;

    // ==========================================================
    // clock_control field layout and reset values
    localparam int         CMC_CLOCK_OUTPUT_DISABLE_BIT = 27;
    localparam int         CMC_BAUD_GEN_DIVIDER_LSB   = 30;
    localparam logic       CMC_CLOCK_OUTPUT_DISABLE_RST = 1'b0;
    localparam logic [1:0] CMC_BAUD_GEN_DIVIDER_RST   = 2'h1;

    // ==========================================================
    // divider counts
    localparam int         CMC_SCC_DIV   = 4;
    localparam logic [1:0] CMC_SCC_LAST  = 2'h3;
    localparam int         CMC_BRG_CNT_W = 8;

    // ==========================================================
    // types
    typedef struct packed {
        logic [3:0] core_divider;
        logic       delay_loop_disable;
        logic [3:0] system_pll_multiplier;
        logic [3:0] system_pll_prediv;
        logic [3:0] comm_proc_divider;
        logic [3:0] bus_divider;
        logic [3:0] core_pll_multiplier;
        logic [3:0] core_pll_prediv;
    } cmc_mode_t;

    typedef struct packed {
        logic       clock_output_disable;
        logic [1:0] baud_gen_divider;
    } cmc_ctrl_t;

    typedef struct packed {
        logic [19:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } cmc_reg_req_t;

    typedef enum logic [1:0] {
        CMC_ST_HOLD,
        CMC_ST_RUN
    } cmc_state_t;

    // ==========================================================
    // helpers
    function automatic logic [31:0] cmc_mode_word(input cmc_mode_t m);
        logic [31:0] w;
        w = '0;
        w[CMC_CORE_PDF_LSB +: CMC_FIELD_W] = m.core_pll_prediv;
        w[CMC_CORE_MF_LSB +: CMC_FIELD_W]  = m.core_pll_multiplier;
        w[CMC_BUS_DF_LSB +: CMC_FIELD_W]   = m.bus_divider;
        w[CMC_CPM_DF_LSB +: CMC_FIELD_W]   = m.comm_proc_divider;
        w[CMC_SYSTEM_PLL_PDF_LSB +: CMC_FIELD_W] = m.system_pll_prediv;
        w[CMC_SYSTEM_PLL_MF_LSB +: CMC_FIELD_W]  = m.system_pll_multiplier;
        w[CMC_DLL_DIS_BIT]                 = m.delay_loop_disable;
        w[CMC_CORE_DF_LSB +: CMC_FIELD_W]  = m.core_divider;
        return w;
    endfunction

    function automatic logic [7:0] cmc_brg_last(input logic [1:0] sel);
        case (sel)
            2'h0:    return 8'h03;
            2'h1:    return 8'h0F;
            2'h2:    return 8'h3F;
            default: return 8'hFF;
        endcase
    endfunction

endpackage

// *** hw/cmc_pin_sync.sv ***
`timescale 1ns/10ps
module cmc_pin_sync
    import cmc_pkg::*;
#(
    parameter int          WIDTH   = 1,
    parameter logic [15:0] RST_VAL = 16'h0000
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_q;

    if (WIDTH < 1 || WIDTH > 16) begin : g_chk
        $error("cmc_pin_sync: WIDTH out of range");
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s1_q <= RST_VAL[WIDTH-1:0];
            s2_q <= RST_VAL[WIDTH-1:0];
            s3_q <= RST_VAL[WIDTH-1:0];
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            level_q <= RST_VAL[WIDTH-1:0];
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end

    assign level_out = level_q;

endmodule

// *** verif/test_clock_mode_configuration.sv ***
`timescale 1ns/10ps
module test_clock_mode_configuration;
    import cmc_pkg::*;

    // ==========================================================
    // stimulus and observed signals
    logic         clk_in;
    logic         rst_in;
    logic         por_n;
    logic [2:0]   pins;
    logic [2:0]   rw_bits;
    cmc_reg_req_t req;
    logic [31:0]  rdata;
    logic         rvalid;
    cmc_mode_t    mode;
    logic         mode_valid;
    cmc_ctrl_t    ctrl;
    logic         scc_en;
    logic         brg_en;
    logic         external_clock_output;
    int           fails;
    int           comparisons;
    int           cycles;

    cmc_clock_mode_cfg uut (
        .clk_in                    (clk_in),
        .rst_in                    (rst_in),
        .power_on_reset_n_in       (por_n),
        .mode_select_pins_in       (pins),
        .reset_word_mode_bits_in   (rw_bits),
        .reg_req_in                (req),
        .reg_rdata_out             (rdata),
        .reg_rvalid_out            (rvalid),
        .clock_mode_out            (mode),
        .mode_valid_out            (mode_valid),
        .clock_ctrl_out            (ctrl),
        .scc_clk_en_out            (scc_en),
        .baud_gen_clk_en_out       (brg_en),
        .external_clock_output_out (external_clock_output)
    );

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    // ==========================================================
    // closing report and hang guard
    task automatic wrap_up();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            wrap_up();
        end
    end

    // ==========================================================
    // compare tasks
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_cnt(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            fails++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // ==========================================================
    // register access, one request per call
    task automatic reg_write(input logic [19:0] a, input logic [31:0] d);
        @(negedge clk_in);
        req.addr  = a;
        req.wdata = d;
        req.wr    = 1'b1;
        @(negedge clk_in);
        req.wr    = 1'b0;
    endtask

    task automatic reg_read(input logic [19:0] a, output logic [31:0] d);
        @(negedge clk_in);
        req.addr = a;
        req.rd   = 1'b1;
        @(negedge clk_in);
        req.rd   = 1'b0;
        check32({31'h0, rvalid}, 32'h1);
        d = rdata;
    endtask

    // ==========================================================
    // expected mode from the six-bit selection
    function automatic cmc_mode_t exp_mode(input logic [5:0] m);
        cmc_mode_t e;
        e.core_pll_prediv       = {2'h0, m[1:0]};
        e.core_pll_multiplier   = 4'h5 + {3'h0, m[2]};
        e.bus_divider           = 4'h1 + {2'h0, m[4:3]};
        e.comm_proc_divider     = {3'h0, m[5]};
        e.system_pll_prediv     = {3'h0, m[3]};
        e.system_pll_multiplier = 4'h5 + {1'h0, m[2:0]};
        e.delay_loop_disable    = 1'b0;
        e.core_divider          = {2'h0, m[5:4]};
        return e;
    endfunction

    function automatic logic [31:0] exp_word(input cmc_mode_t e);
        return {e.core_divider, 2'h0, e.delay_loop_disable, 1'h0, e.system_pll_multiplier,
                e.system_pll_prediv, e.comm_proc_divider, e.bus_divider,
                e.core_pll_multiplier, e.core_pll_prediv};
    endfunction

    // cycles between two events: 0 scc pulse, 1 baud pulse, 2 external_clock_output rise
    task automatic measure(input int which, output int per);
        int   n;
        int   seen;
        logic prev;
        logic cur;
        logic hit;
        seen = 0;
        per  = 0;
        n    = 0;
        prev = 1'b1;
        while (seen < 2 && n < 1200) begin
            @(negedge clk_in);
            n++;
            cur  = (which == 0) ? scc_en : (which == 1) ? brg_en : external_clock_output;
            hit  = (which == 2) ? (cur === 1'b1 && prev === 1'b0) : (cur === 1'b1);
            prev = cur;
            if (seen == 1) begin
                per++;
            end
            if (hit) begin
                seen++;
            end
        end
    endtask

    // power-on cycle with a chosen selection, then checks
    task automatic power_on(input logic [5:0] m);
        logic [31:0] d;
        cmc_mode_t   e;
        int          per;
        e = exp_mode(m);
        @(negedge clk_in);
        por_n   = 1'b0;
        pins    = m[2:0];
        rw_bits = m[5:3];
        repeat (6) @(negedge clk_in);
        por_n = 1'b1;
        repeat (8) @(negedge clk_in);
        check32({31'h0, mode_valid}, 32'h1);
        check32({3'h0, mode}, {3'h0, e});
        reg_read(CMC_MODE_STATUS_OFS, d);
        check32(d, exp_word(e));
        reg_read(CMC_CLOCK_CONTROL_OFS, d);
        check32(d, 32'h4000_0000);
        measure(2, per);
        check_cnt(per, int'(e.bus_divider) + 1);
        pins    = ~m[2:0];
        rw_bits = ~m[5:3];
        repeat (10) @(negedge clk_in);
        check32({3'h0, mode}, {3'h0, e});
    endtask

    // ==========================================================
    // main sequence
    logic [5:0] sel_tab [4] = '{6'h00, 6'h3F, 6'h2A, 6'h15};

    initial begin
        logic [31:0] d;
        int          per;
        int          highs;
        cmc_mode_t   e;
        fails       = 0;
        comparisons = 0;
        cycles      = 0;
        rst_in      = 1'b1;
        por_n       = 1'b0;
        pins        = 3'h0;
        rw_bits     = 3'h0;
        req         = '0;
        repeat (5) @(negedge clk_in);
        rst_in = 1'b0;
        @(negedge clk_in);
        check32({31'h0, mode_valid}, 32'h0);
        check32({29'h0, ctrl}, {29'h0, 1'b0, 2'h1});
        for (int i = 0; i < 4; i++) begin
            power_on(sel_tab[i]);
        end
        e = exp_mode(sel_tab[3]);
        measure(0, per);
        check_cnt(per, 4);
        for (int s = 0; s < 4; s++) begin
            reg_write(CMC_CLOCK_CONTROL_OFS, {s[1:0], 30'h0});
            reg_read(CMC_CLOCK_CONTROL_OFS, d);
            check32(d, {s[1:0], 30'h0});
            measure(1, per);
            check_cnt(per, 4 << (2 * s));
            check32({3'h0, mode}, {3'h0, e});
        end
        reg_write(CMC_CLOCK_CONTROL_OFS, 32'h4800_0000);
        highs = 0;
        repeat (20) begin
            @(negedge clk_in);
            if (external_clock_output !== 1'b0) begin
                highs++;
            end
        end
        check_cnt(highs, 0);
        reg_write(CMC_CLOCK_CONTROL_OFS, 32'h4000_0000);
        measure(2, per);
        check_cnt(per, int'(e.bus_divider) + 1);
        reg_write(CMC_CLOCK_CONTROL_OFS, 32'hC800_0000);
        reg_read(CMC_CLOCK_CONTROL_OFS, d);
        check32(d, 32'hC800_0000);
        reg_read(20'h10C84, d);
        check32(d, 32'h0);
        reg_write(CMC_MODE_STATUS_OFS, 32'h0000_0000);
        reg_read(CMC_MODE_STATUS_OFS, d);
        check32(d, exp_word(e));
        check32({3'h0, mode}, {3'h0, e});
        wrap_up();
    end

endmodule
